// [logic/analog_value_scaler.sv]
// AXI4-Lite register block for the analog value scaler and block options.
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module analog_value_scaler
  import scaler_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] analog_voltage_input,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic signed [31:0] scaled_actual_value,
  output logic [7:0] special_function_block
);
  logic [15:0] gain;
  logic [15:0] offset;
  logic [7:0] invert;
  logic [7:0] connect;
  logic [7:0] block_in;
  logic [31:0] retain;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire logic signed [31:0] next_value;
  wire logic do_write;
  wire logic [31:0] merged;
  wire logic [15:0] gain_in;
  wire logic [15:0] offs_in;
  wire logic wr_ok;
  wire logic rd_ok;
  wire logic [31:0] rd_word;
  wire logic [7:0] next_block;
  wire logic [31:0] rd_word_w;

  function automatic logic [15:0] limit(input logic [15:0] v,
                                       input logic [15:0] lim);
    if ($signed(v) > $signed(lim))
      limit = lim;
    else if ($signed(v) < -$signed(lim))
      limit = -lim;
    else
      limit = v;
  endfunction : limit

  function automatic logic known(input logic [7:0] a);
    known = (a <= OFS_CAPABLE) && (a[1:0] == 2'h0);
  endfunction : known

  scale_core u_core (
    .raw(analog_voltage_input),
    .gain(gain),
    .offset(offset),
    .value(next_value)
  );

  // Byte lanes are merged into the current word so that partial writes work.
  assign merged = {w_strb[3] ? w_data[31:24] : rd_word_w[31:24],
                   w_strb[2] ? w_data[23:16] : rd_word_w[23:16],
                   w_strb[1] ? w_data[15:8] : rd_word_w[15:8],
                   w_strb[0] ? w_data[7:0] : rd_word_w[7:0]};
  assign rd_word_w = reg_word(aw_addr);
  assign gain_in = limit(merged[15:0], GAIN_MAX); // see [RULE_04]
  assign offs_in = limit(merged[15:0], OFFS_MAX); // see [RULE_05]
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok = known(aw_addr);
  assign rd_ok = known(s_axi_araddr);
  assign rd_word = reg_word(s_axi_araddr);
  // Unconnected inputs are forced low before inversion is applied.
  assign next_block = (block_in & connect) ^ invert; // see [RULE_08] [RULE_06]

  function automatic logic [31:0] reg_word(input logic [7:0] a);
    case (a)
      OFS_RAW: reg_word = {20'h00000, analog_voltage_input};
      OFS_GAIN: reg_word = {{16{gain[15]}}, gain};
      OFS_OFFSET: reg_word = {{16{offset[15]}}, offset};
      OFS_VALUE: reg_word = scaled_actual_value;
      OFS_INVERT: reg_word = {24'h000000, invert};
      OFS_CONNECT: reg_word = {24'h000000, connect};
      OFS_RETAIN: reg_word = retain;
      OFS_BLOCK_IN: reg_word = {24'h000000, block_in};
      OFS_CAPABLE: reg_word = RETAIN_CAPABLE;
      default: reg_word = 32'h00000000;
    endcase
  endfunction : reg_word

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Retention selections reset to off, as after a power failure.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain <= GAIN_RESET;
      offset <= OFFS_RESET;
      invert <= 8'h00;
      connect <= 8'h00;
      block_in <= 8'h00;
      retain <= 32'h00000000; // see [RULE_09]
    end else if (do_write) begin
      case (aw_addr)
        OFS_GAIN: gain <= gain_in;
        OFS_OFFSET: offset <= offs_in;
        OFS_INVERT: invert <= merged[7:0];
        OFS_CONNECT: connect <= merged[7:0];
        OFS_BLOCK_IN: block_in <= merged[7:0];
        // Capability mask silently drops requests for non-capable blocks.
        OFS_RETAIN: retain <= merged & RETAIN_CAPABLE; // see [RULE_07]
        default: gain <= gain;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scaled_actual_value <= 32'sh00000000;
      special_function_block <= 8'h00;
    end else begin
      scaled_actual_value <= next_value; // see [RULE_03]
      special_function_block <= next_block; // see [RULE_06]
    end
  end

  // The settings may change on the edge that shows the result, so the
  // expected value uses the settings that the result was computed from.
  clamp_a: assert property ( // see [RULE_02]
    @(posedge clk) disable iff (!rst_n)
    analog_voltage_input > RAW_MAX
    |=> scaled_actual_value == 32'(1000 * $signed($past(gain)) / 100)
        + 32'($signed($past(offset))))
    else $error("Clamp to full scale failed.");
  value_track_a: assert property ( // see [RULE_03]
    @(posedge clk) disable iff (!rst_n)
    analog_voltage_input <= RAW_MAX
    |=> scaled_actual_value == 32'($signed({20'h00000,
        $past(analog_voltage_input)}) * $signed($past(gain)) / 100)
        + 32'($signed($past(offset))))
    else $error("Actual value not scaled.");
  gain_range_a: assert property ( // see [RULE_04]
    @(posedge clk) disable iff (!rst_n)
    $signed(gain) <= 1000 && $signed(gain) >= -1000)
    else $error("Gain out of range.");
  offset_range_a: assert property ( // see [RULE_05]
    @(posedge clk) disable iff (!rst_n)
    $signed(offset) <= 10000 && $signed(offset) >= -10000)
    else $error("Offset out of range.");
  invert_path_a: assert property ( // see [RULE_06]
    @(posedge clk) disable iff (!rst_n)
    ##1 special_function_block == (($past(block_in) & $past(connect))
                                   ^ $past(invert)))
    else $error("Block input inversion wrong.");
  retain_cap_a: assert property ( // see [RULE_07]
    @(posedge clk) disable iff (!rst_n)
    (retain & ~RETAIN_CAPABLE) == 32'h00000000)
    else $error("Retention set on incapable block.");
  open_input_a: assert property ( // see [RULE_08]
    @(posedge clk) disable iff (!rst_n)
    ##1 (($past(connect) | $past(invert)) == 8'h00)
    |-> special_function_block == 8'h00)
    else $error("Unconnected input not zero.");
  trunc_a: assert property ( // see [RULE_10]
    @(posedge clk) disable iff (!rst_n)
    analog_voltage_input == 12'h002 && gain == 16'h000A && offset == 16'h0
    |=> scaled_actual_value == 32'sh00000000)
    else $error("Fraction not truncated.");
endmodule : analog_value_scaler

// [logic/scale_core.sv]
// Combinational gain and offset arithmetic for one analog value.
`timescale 1ns/1ps
module scale_core
  import scaler_pkg::*;
(
  input wire logic [11:0] raw,
  input wire logic signed [15:0] gain,
  input wire logic signed [15:0] offset,
  output logic signed [31:0] value
);
  wire logic [11:0] clamped;
  wire logic signed [31:0] product;
  wire logic signed [31:0] quotient;
  // Above full scale the converter result saturates.
  assign clamped = (raw > RAW_MAX) ? RAW_MAX : raw; // see [RULE_02]
  // Input scale is 0..1000 straight from the converter.
  assign product = $signed({20'h00000, clamped}) * 32'(gain); // see [RULE_01]
  // Signed division truncates toward zero, dropping the fraction.
  assign quotient = product / GAIN_DIV; // see [RULE_10]
  assign value = quotient + 32'(offset); // see [RULE_03]
endmodule : scale_core

// [logic/scaler_pkg.sv]
// Constants, register map and function catalogue of the analog value scaler.
// Functional notes
// [RULE_01] Map 0..10 V linearly onto 0..1000.
// [RULE_02] Clamp inputs above full scale to 1000.
// [RULE_03] Actual value is input times gain plus offset.
// [RULE_04] Signed gain, hundredths, limited to +-10.00.
// [RULE_05] Signed offset limited to +-10000.
// [RULE_06] Each block input may be inverted individually.
// [RULE_07] Retention only for retention-capable functions.
// [RULE_08] Unconnected block inputs read as zero.
// [RULE_09] Retention off by default, lost on power fail.
// [RULE_10] Fraction of gain product is truncated.
package scaler_pkg;
  localparam int RAW_W = 12;
  localparam logic [11:0] RAW_MAX = 12'h3E8;
  localparam logic [15:0] GAIN_MAX = 16'h03E8;
  localparam logic [15:0] OFFS_MAX = 16'h2710;
  localparam logic [15:0] GAIN_RESET = 16'h0064;
  localparam logic [15:0] OFFS_RESET = 16'h0000;
  localparam int GAIN_DIV = 100;
  localparam int NUM_FUNC = 32;
  // Bit n is catalogue entry n, on-delay first and math error check last.
  // The random generator, time switches and analog functions stay clear.
  localparam logic [31:0] RETAIN_CAPABLE = 32'h3700337F;
  localparam logic [7:0] OFS_RAW = 8'h00;
  localparam logic [7:0] OFS_GAIN = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_VALUE = 8'h0C;
  localparam logic [7:0] OFS_INVERT = 8'h10;
  localparam logic [7:0] OFS_CONNECT = 8'h14;
  localparam logic [7:0] OFS_RETAIN = 8'h18;
  localparam logic [7:0] OFS_BLOCK_IN = 8'h1C;
  localparam logic [7:0] OFS_CAPABLE = 8'h20;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : scaler_pkg

// [verif/adc_model.sv]
// Behavioural converter that presents one sampled code per clock.
`timescale 1ns/1ps
module adc_model (
  input wire logic clk,
  input wire logic [11:0] level,
  output logic [11:0] result
);
  // Codes above full scale are passed on so the clamp is exercised.
  always_ff @(posedge clk) begin
    result <= level;
  end
endmodule : adc_model

// [verif/analog_value_scaler_tb.sv]
// Self-checking bench for the analog value scaler.
`timescale 1ns/1ps
module analog_value_scaler_tb;
  import scaler_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] level = 12'h000;
  logic [11:0] adc;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdv;
  logic signed [31:0] sav;
  logic [7:0] sfb;
  int err_total = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  adc_model adc_model_inst (.clk(clk), .level(level), .result(adc));
  analog_value_scaler analog_value_scaler_inst (
    .clk(clk), .rst_n(rst_n), .analog_voltage_input(adc),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scaled_actual_value(sav),
    .special_function_block(sfb)
  );
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 50 && !bvalid; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    resp = bresp;
    bready <= 1'h0;
    if (n == 50) chk(32'h0, 32'h1);
    if (n == 50) complete_run();
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 50 && !rvalid; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end
    rdv = rdata;
    resp = rresp;
    rready <= 1'h0;
    if (n == 50) chk(32'h0, 32'h1);
    if (n == 50) complete_run();
  endtask : rd_reg
  // Gain and offset stay in range here; saturation has its own test.
  task automatic scale(input logic [11:0] raw, input int g, input int o);
    int r;
    level <= raw;
    wr(OFS_GAIN, g);
    wr(OFS_OFFSET, o);
    r = (raw > RAW_MAX) ? RAW_MAX : raw;
    repeat (3) @(posedge clk);
    chk(sav, r * g / GAIN_DIV + o);
  endtask : scale
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    rd_reg(OFS_GAIN);
    chk(rdv, 32'h00000064);
    rd_reg(OFS_RETAIN);
    chk(rdv, 32'h00000000);
    rd_reg(OFS_CAPABLE);
    chk(rdv, 32'h3700337F);
    $display("test reset_values done");
    scale(12'h000, 10, -10000);
    scale(12'h3E8, 10, -10000);
    scale(12'h2A3, 400, 1000);
    scale(12'h12C, 10, -30);
    scale(12'hFFF, 100, 500);
    scale(12'h3E9, -1000, 10000);
    scale(12'h002, 10, 0);
    scale(12'h003, -50, 0);
    scale(12'h002, 1000, 0);
    rd_reg(OFS_VALUE);
    chk(rdv, 32'h00000014);
    $display("test scaling done");
    wr(OFS_GAIN, 32'h000007D0);
    rd_reg(OFS_GAIN);
    chk(rdv, 32'h000003E8);
    wr(OFS_GAIN, 32'hFFFFF830);
    rd_reg(OFS_GAIN);
    chk(rdv, 32'hFFFFFC18);
    wr(OFS_OFFSET, 32'h00004E20);
    rd_reg(OFS_OFFSET);
    chk(rdv, 32'h00002710);
    wr(OFS_OFFSET, 32'hFFFFB1E0);
    rd_reg(OFS_OFFSET);
    chk(rdv, 32'hFFFFD8F0);
    $display("test saturation done");
    wr(OFS_BLOCK_IN, 32'h000000A5);
    wr(OFS_CONNECT, 32'h0000000F);
    wr(OFS_INVERT, 32'h00000033);
    repeat (3) @(posedge clk);
    chk(sfb, 32'h00000036);
    // Only lane 1 is enabled, so the low byte must keep its old value.
    wstrb <= 4'h2;
    wr(OFS_BLOCK_IN, 32'h0000FF5A);
    wstrb <= 4'hF;
    rd_reg(OFS_BLOCK_IN);
    chk(rdv, 32'h000000A5);
    $display("test block_inputs done");
    wr(OFS_RETAIN, 32'hFFFFFFFF);
    rd_reg(OFS_RETAIN);
    chk(rdv, 32'h3700337F);
    $display("test retention done");
    wr(OFS_VALUE, 32'h00000005);
    chk(resp, 32'h0);
    wr(8'h40, 32'h00000001);
    chk(resp, 32'h2);
    rd_reg(8'h40);
    chk(rdv, 32'h0);
    chk(resp, 32'h2);
    $display("test bus_errors done");
    complete_run();
  end
endmodule : analog_value_scaler_tb
